// file: sfc_defines.svh
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH
// How it works
// - Bit 0 enables transmit queue, resets 0
// - Bit 1 enables receive queue, resets 0
// - Bits 5:4 read 0x1: eight 16-bit entries
// - Bit 12: transmit DMA request while enabled and not full
// - Bit 13: receive DMA request while not empty
// - Bit 14: transmit level wakes DMA service
// - Bit 15: receive level wakes DMA service
// - Wake bits clear: no level wake, reset 0
// - Level wake rouses DMA only, not processor
// - Writing one to bit 16 empties transmit queue
// - Writing one to bit 17 empties receive queue
`define SFC_ADDR_W    12
`define SFC_CFG_OFF   12'hE00
`define SFC_STAT_OFF  12'hE04
`define SFC_TRIG_OFF  12'hE08
`define SFC_EN_TX     0
`define SFC_EN_RX     1
`define SFC_SIZE_LO   4
`define SFC_SIZE_VAL  2'h1
`define SFC_DMA_TX    12
`define SFC_DMA_RX    13
`define SFC_WAKE_TX   14
`define SFC_WAKE_RX   15
`define SFC_FLUSH_TX  16
`define SFC_FLUSH_RX  17
`define SFC_TXEMPTY   4
`define SFC_TXNOTFULL 5
`define SFC_RXNOTEMP  6
`define SFC_RXFULL    7
`define SFC_TRANSMIT_TRIGGER_LEVEL_LO  8
`define SFC_RECEIVE_TRIGGER_LEVEL_LO  16
`define SFC_LVL_W     5
`define SFC_TRIG_TX   0
`define SFC_TRIG_RX   8
`define SFC_TRIG_W    4
`define SFC_DEPTH     8
`define SFC_WIDTH     16
`endif

// file: sfc_pkg.sv
package sfc_pkg;
	typedef enum logic [1:0]
	{
		SFC_OKAY   = 2'h0,
		SFC_SLVERR = 2'h2
	} sfc_resp_t;
endpackage

// file: sfc_fifo_config.sv
`timescale 1ns/100ps
`include "sfc_defines.svh"
module sfc_fifo_config
	import sfc_pkg::*;
#(
	parameter int DEPTH = `SFC_DEPTH,
	parameter int WIDTH = `SFC_WIDTH
)
(
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [`SFC_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output wire logic                   s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output wire logic                   s_axi_wready,
	output wire logic [1:0]             s_axi_bresp,
	output wire logic                   s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [`SFC_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output wire logic                   s_axi_arready,
	output wire logic [31:0]            s_axi_rdata,
	output wire logic [1:0]             s_axi_rresp,
	output wire logic                   s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic [WIDTH-1:0]       tx_in_data,
	input  wire logic                   tx_in_valid,
	output wire logic                   tx_in_ready,
	output wire logic [WIDTH-1:0]       tx_out_data,
	output wire logic                   tx_out_valid,
	input  wire logic                   tx_out_ready,
	input  wire logic [WIDTH-1:0]       rx_in_data,
	input  wire logic                   rx_in_valid,
	output wire logic                   rx_in_ready,
	output wire logic [WIDTH-1:0]       rx_out_data,
	output wire logic                   rx_out_valid,
	input  wire logic                   rx_out_ready,
	output wire logic                   tx_dma_request,
	output wire logic                   rx_dma_request,
	output wire logic                   dma_wakeup
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int LW = `SFC_LVL_W;
	localparam int TW = `SFC_TRIG_W;
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [`SFC_ADDR_W-1:0] CFG_A = `SFC_CFG_OFF;
	localparam logic [`SFC_ADDR_W-1:0] STAT_A = `SFC_STAT_OFF;
	localparam logic [`SFC_ADDR_W-1:0] TRIG_A = `SFC_TRIG_OFF;
	generate
		if (DEPTH < 4 || (1 << PW) != DEPTH || CW > LW || WIDTH < 1 || WIDTH > 32)
		begin : g_bad
			$error("sfc_fifo_config: unsupported DEPTH or WIDTH");
		end
	endgenerate
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wp;
		logic [PW-1:0]               rp;
		logic [CW-1:0]               cnt;
		logic [1:0][WIDTH-1:0]       stage;
		logic [1:0]                  scnt;
		logic                        in_ready;
		logic                        out_valid;
	} sfc_queue_t;
	typedef struct packed {
		sfc_queue_t [1:0]       q;
		logic [1:0]             en;
		logic [1:0]             dma;
		logic [1:0]             wake;
		logic [1:0][TW-1:0]     trig;
		logic                   aw_got;
		logic                   w_got;
		logic [`SFC_ADDR_W-1:0] waddr;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   awready;
		logic                   wready;
		logic                   bvalid;
		sfc_resp_t              bresp;
		logic                   arready;
		logic                   rvalid;
		logic [31:0]            rdata;
		sfc_resp_t              rresp;
		logic                   rd_cfg;
		logic [1:0]             dma_req;
		logic                   wakeup;
	} sfc_state_t;
	sfc_state_t             state_reg;
	sfc_state_t             state_next;
	logic [1:0]             in_valid;
	logic [1:0]             out_ready;
	logic [1:0][WIDTH-1:0]  in_data;
	logic [1:0][CW-1:0]     level;
	logic [1:0][CW-1:0]     lvl_n;
	logic [1:0]             flush;
	logic                   wr_fire;
	logic                   rd_ok;
	logic [31:0]            rd_word;
	// Index 0 is transmit, index 1 is receive
	assign in_valid = {rx_in_valid, tx_in_valid};
	assign out_ready = {rx_out_ready, tx_out_ready};
	assign in_data = {rx_in_data, tx_in_data};
	assign wr_fire = state_reg.aw_got && state_reg.w_got;
	always_comb
	begin
		state_next = state_reg;
		flush = 2'h0;
		rd_ok = 1'b1;
		rd_word = 32'h0;
		for (int d = 0; d < 2; d++)
		begin
			level[d] = state_reg.q[d].cnt + CW'(state_reg.q[d].scnt);
		end
		// Read decode; reserved bits read zero
		if (s_axi_araddr[`SFC_ADDR_W-1:2] == CFG_A[`SFC_ADDR_W-1:2])
		begin
			rd_word[`SFC_EN_TX] = state_reg.en[0];
			rd_word[`SFC_EN_RX] = state_reg.en[1];
			rd_word[`SFC_SIZE_LO +: 2] = `SFC_SIZE_VAL;
			rd_word[`SFC_DMA_TX] = state_reg.dma[0];
			rd_word[`SFC_DMA_RX] = state_reg.dma[1];
			rd_word[`SFC_WAKE_TX] = state_reg.wake[0];
			rd_word[`SFC_WAKE_RX] = state_reg.wake[1];
		end
		else if (s_axi_araddr[`SFC_ADDR_W-1:2] == STAT_A[`SFC_ADDR_W-1:2])
		begin
			rd_word[`SFC_TXEMPTY] = level[0] == '0;
			rd_word[`SFC_TXNOTFULL] = level[0] < FULL;
			rd_word[`SFC_RXNOTEMP] = level[1] != '0;
			rd_word[`SFC_RXFULL] = level[1] == FULL;
			rd_word[`SFC_TRANSMIT_TRIGGER_LEVEL_LO +: LW] = LW'(level[0]);
			rd_word[`SFC_RECEIVE_TRIGGER_LEVEL_LO +: LW] = LW'(level[1]);
		end
		else if (s_axi_araddr[`SFC_ADDR_W-1:2] == TRIG_A[`SFC_ADDR_W-1:2])
		begin
			rd_word[`SFC_TRIG_TX +: TW] = state_reg.trig[0];
			rd_word[`SFC_TRIG_RX +: TW] = state_reg.trig[1];
		end
		else
		begin
			rd_ok = 1'b0;
		end
		// Write channel: address and data taken in either order
		if (state_reg.awready && s_axi_awvalid)
		begin
			state_next.aw_got = 1'b1;
			state_next.waddr = s_axi_awaddr;
		end
		if (state_reg.wready && s_axi_wvalid)
		begin
			state_next.w_got = 1'b1;
			state_next.wdata = s_axi_wdata;
			state_next.wstrb = s_axi_wstrb;
		end
		if (state_reg.bvalid && s_axi_bready)
		begin
			state_next.bvalid = 1'b0;
		end
		if (wr_fire)
		begin
			state_next.aw_got = 1'b0;
			state_next.w_got = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = SFC_OKAY;
			if (state_reg.waddr[`SFC_ADDR_W-1:2] == CFG_A[`SFC_ADDR_W-1:2])
			begin
				if (state_reg.wstrb[0])
				begin
					state_next.en[0] = state_reg.wdata[`SFC_EN_TX];
					state_next.en[1] = state_reg.wdata[`SFC_EN_RX];
				end
				if (state_reg.wstrb[1])
				begin
					state_next.dma[0] = state_reg.wdata[`SFC_DMA_TX];
					state_next.dma[1] = state_reg.wdata[`SFC_DMA_RX];
					state_next.wake[0] = state_reg.wdata[`SFC_WAKE_TX];
					state_next.wake[1] = state_reg.wdata[`SFC_WAKE_RX];
				end
				if (state_reg.wstrb[2])
				begin
					flush[0] = state_reg.wdata[`SFC_FLUSH_TX];
					flush[1] = state_reg.wdata[`SFC_FLUSH_RX];
				end
			end
			else if (state_reg.waddr[`SFC_ADDR_W-1:2] == TRIG_A[`SFC_ADDR_W-1:2])
			begin
				if (state_reg.wstrb[0])
				begin
					state_next.trig[0] = state_reg.wdata[`SFC_TRIG_TX +: TW];
				end
				if (state_reg.wstrb[1])
				begin
					state_next.trig[1] = state_reg.wdata[`SFC_TRIG_RX +: TW];
				end
			end
			else if (state_reg.waddr[`SFC_ADDR_W-1:2] != STAT_A[`SFC_ADDR_W-1:2])
			begin
				state_next.bresp = SFC_SLVERR;
			end
		end
		state_next.awready = !state_next.aw_got && !state_next.bvalid;
		state_next.wready = !state_next.w_got && !state_next.bvalid;
		// Read channel
		if (state_reg.rvalid && s_axi_rready)
		begin
			state_next.rvalid = 1'b0;
		end
		if (state_reg.arready && s_axi_arvalid)
		begin
			state_next.rvalid = 1'b1;
			state_next.rdata = rd_word;
			state_next.rresp = rd_ok ? SFC_OKAY : SFC_SLVERR;
			state_next.rd_cfg = s_axi_araddr[`SFC_ADDR_W-1:2] == CFG_A[`SFC_ADDR_W-1:2];
		end
		state_next.arready = !state_next.rvalid;
		// Queue plus two-entry output stage per direction
		for (int d = 0; d < 2; d++)
		begin
			if (state_reg.q[d].out_valid && out_ready[d])
			begin
				state_next.q[d].stage[0] = state_reg.q[d].stage[1];
				state_next.q[d].scnt = state_reg.q[d].scnt - 2'h1;
			end
			if (state_reg.q[d].cnt != '0 && state_next.q[d].scnt != 2'h2)
			begin
				state_next.q[d].stage[state_next.q[d].scnt[0]] = state_reg.q[d].mem[state_reg.q[d].rp];
				state_next.q[d].rp = state_reg.q[d].rp + PW'(1);
				state_next.q[d].cnt = state_reg.q[d].cnt - CW'(1);
				state_next.q[d].scnt = state_next.q[d].scnt + 2'h1;
			end
			if (in_valid[d] && state_reg.q[d].in_ready)
			begin
				state_next.q[d].mem[state_reg.q[d].wp] = in_data[d];
				state_next.q[d].wp = state_reg.q[d].wp + PW'(1);
				state_next.q[d].cnt = state_next.q[d].cnt + CW'(1);
			end
			// Flush or disable discards all held entries
			if (flush[d] || !state_next.en[d])
			begin
				state_next.q[d].wp = '0;
				state_next.q[d].rp = '0;
				state_next.q[d].cnt = '0;
				state_next.q[d].scnt = 2'h0;
			end
			lvl_n[d] = state_next.q[d].cnt + CW'(state_next.q[d].scnt);
			state_next.q[d].in_ready = state_next.en[d] && (lvl_n[d] < FULL);
			state_next.q[d].out_valid = state_next.q[d].scnt != 2'h0;
		end
		state_next.dma_req[0] = state_next.dma[0] && state_next.en[0] && (lvl_n[0] < FULL);
		state_next.dma_req[1] = state_next.dma[1] && state_next.en[1] && (lvl_n[1] != '0);
		// Wake goes to DMA service only; no level wake without the bit
		state_next.wakeup = (state_next.wake[0] && state_next.en[0]
			&& (LW'(lvl_n[0]) <= LW'(state_next.trig[0])))
			|| (state_next.wake[1] && state_next.en[1]
			&& (LW'(lvl_n[1]) > LW'(state_next.trig[1])));
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign s_axi_awready = state_reg.awready;
	assign s_axi_wready = state_reg.wready;
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_arready = state_reg.arready;
	assign s_axi_rdata = state_reg.rdata;
	assign s_axi_rresp = state_reg.rresp;
	assign s_axi_rvalid = state_reg.rvalid;
	assign tx_in_ready = state_reg.q[0].in_ready;
	assign tx_out_data = state_reg.q[0].stage[0];
	assign tx_out_valid = state_reg.q[0].out_valid;
	assign rx_in_ready = state_reg.q[1].in_ready;
	assign rx_out_data = state_reg.q[1].stage[0];
	assign rx_out_valid = state_reg.q[1].out_valid;
	assign tx_dma_request = state_reg.dma_req[0];
	assign rx_dma_request = state_reg.dma_req[1];
	assign dma_wakeup = state_reg.wakeup;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_taken_s;
		wr_fire;
	endsequence
	sequence tx_flush_s;
		wr_fire && flush[0];
	endsequence
	sequence rx_flush_s;
		wr_fire && flush[1];
	endsequence
	sequence queue_empty_tx_s;
		state_reg.q[0].cnt == '0 && !tx_out_valid;
	endsequence
	sequence queue_empty_rx_s;
		state_reg.q[1].cnt == '0 && !rx_out_valid;
	endsequence
	write_resp_a: assert property (wr_taken_s |=> s_axi_bvalid ##0 !s_axi_awready [*1])
		else $error("write response missing");
	tx_enable_gate_a: assert property (tx_in_ready |-> state_reg.en[0] && level[0] < FULL)
		else $error("tx ready while disabled or full");
	rx_enable_gate_a: assert property (rx_in_ready |-> state_reg.en[1] && level[1] < FULL)
		else $error("rx ready while disabled or full");
	size_field_a: assert property (s_axi_rvalid && state_reg.rd_cfg |-> s_axi_rdata[5:4] == 2'h1)
		else $error("size field wrong");
	tx_dma_req_a: assert property (tx_dma_request == (state_reg.dma[0] && state_reg.en[0] && level[0] < FULL))
		else $error("tx dma request mismatch");
	rx_dma_req_a: assert property (rx_dma_request |-> state_reg.dma[1] && level[1] != '0)
		else $error("rx dma request without data");
	rx_dma_drop_a: assert property (!state_reg.en[1] |-> !rx_dma_request)
		else $error("rx dma request while disabled");
	tx_wake_a: assert property (state_reg.wake[0] && state_reg.en[0]
		&& LW'(level[0]) <= LW'(state_reg.trig[0]) |-> dma_wakeup)
		else $error("tx level wake missing");
	rx_wake_a: assert property (state_reg.wake[1] && state_reg.en[1]
		&& LW'(level[1]) > LW'(state_reg.trig[1]) |-> dma_wakeup)
		else $error("rx level wake missing");
	wake_gate_a: assert property (dma_wakeup |-> state_reg.wake != 2'h0)
		else $error("wake without wake bit");
	tx_flush_a: assert property (tx_flush_s |=> queue_empty_tx_s)
		else $error("tx flush left data");
	rx_flush_a: assert property (rx_flush_s |=> queue_empty_rx_s)
		else $error("rx flush left data");
	reset_cfg_a: assert property ($rose(aresetn) |-> state_reg.en == 2'h0 && state_reg.wake == 2'h0)
		else $error("config not reset");
endmodule

// file: sfc_dma_model.sv
`timescale 1ns/100ps
module sfc_dma_model
	import sfc_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        go,
	input  wire logic        stall,
	input  wire logic        tx_dma_request,
	input  wire logic        tx_in_ready,
	output logic      [15:0] tx_in_data,
	output logic             tx_in_valid,
	input  wire logic        rx_dma_request,
	input  wire logic [15:0] rx_out_data,
	input  wire logic        rx_out_valid,
	output logic             rx_out_ready,
	output logic      [7:0]  rx_seen,
	output logic      [15:0] rx_last
);
	logic [15:0] word_reg;
	logic [15:0] word_next;
	assign word_next = word_reg + {15'h0, tx_in_valid && tx_in_ready};
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{tx_in_valid, rx_out_ready, rx_seen, rx_last, word_reg} <= '0;
			tx_in_data <= 16'hFFFF;
		end
		else
		begin
			word_reg <= word_next;
			// Held until taken; idle data toggles so nothing stale is seen
			if (!tx_in_valid || tx_in_ready)
			begin
				tx_in_valid <= go && tx_dma_request;
				tx_in_data <= (go && tx_dma_request) ? word_next : ~tx_in_data;
			end
			rx_out_ready <= !stall && rx_dma_request;
			if (rx_out_valid && rx_out_ready)
			begin
				rx_seen <= rx_seen + 8'h01;
				rx_last <= rx_out_data;
			end
		end
	end
endmodule

// file: serial_fifo_configuration_tb.sv
`timescale 1ns/100ps
`include "sfc_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
 $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module serial_fifo_configuration_tb
	import sfc_pkg::*;
;
	logic aclk = 0, aresetn = 0, go = 0, stall = 1;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs, wr_resp;
	logic [15:0] tx_in_data, tx_out_data, rx_out_data, rx_last, rx_in_data = '0;
	logic tx_in_valid, tx_in_ready, tx_out_valid, rx_in_ready, rx_out_valid, rx_out_ready;
	logic tx_out_ready = 0, rx_in_valid = 0;
	logic tx_dma_request, rx_dma_request, dma_wakeup;
	logic [7:0] rx_seen;
	int err_total = 0, comparisons = 0, ticks = 0, n;
	sfc_fifo_config #(.DEPTH(8), .WIDTH(16)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.tx_in_data(tx_in_data), .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready),
		.tx_out_data(tx_out_data), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
		.rx_in_data(rx_in_data), .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready),
		.rx_out_data(rx_out_data), .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready),
		.tx_dma_request(tx_dma_request), .rx_dma_request(rx_dma_request), .dma_wakeup(dma_wakeup));
	sfc_dma_model dma (.aclk(aclk), .aresetn(aresetn), .go(go), .stall(stall),
		.tx_dma_request(tx_dma_request), .tx_in_ready(tx_in_ready), .tx_in_data(tx_in_data),
		.tx_in_valid(tx_in_valid), .rx_dma_request(rx_dma_request), .rx_out_data(rx_out_data),
		.rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready), .rx_seen(rx_seen), .rx_last(rx_last));
	initial
	begin
		forever #5 aclk = ~aclk;
	end
	task report_and_stop;
		if (err_total == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Every wait after the reset delay passes through here, so a hang runs out the budget
	task tick;
		@(posedge aclk);
		ticks++;
		if (ticks > 20000)
		begin
			err_total++;
			report_and_stop();
		end
	endtask
	task axi_write(input logic [11:0] a, input logic [31:0] d);
		logic aw_done, w_done;
		aw_done = 0;
		w_done = 0;
		tick();
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(aw_done && w_done))
		begin
			tick();
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_done = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_done = 1;
				s_axi_wvalid <= 0;
			end
		end
		do tick(); while (!s_axi_bvalid);
		wr_resp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task axi_read(input logic [11:0] a);
		tick();
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do tick(); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do tick(); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task push_rx(input logic [15:0] d);
		tick();
		rx_in_data <= d;
		rx_in_valid <= 1;
		do tick(); while (!rx_in_ready);
		rx_in_valid <= 0;
		rx_in_data <= ~d;
	endtask
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		axi_read(`SFC_CFG_OFF);
		`CHK(rd, 32'h00000010)
		axi_read(`SFC_STAT_OFF);
		`CHK(rd, 32'h00000030)
		`CHK({tx_dma_request, rx_dma_request, dma_wakeup}, 3'h0)
		axi_read(12'h100);
		`CHK({rs, rd}, {SFC_SLVERR, 32'h00000000})
		axi_write(12'h100, 32'h0000FFFF);
		`CHK(wr_resp, SFC_SLVERR)
		axi_write(`SFC_CFG_OFF, 32'h00001001);
		`CHK({wr_resp, tx_dma_request}, {SFC_OKAY, 1'b1})
		axi_read(`SFC_CFG_OFF);
		`CHK(rd, 32'h00001011)
		go <= 1;
		while (tx_dma_request) tick();
		go <= 0;
		axi_read(`SFC_STAT_OFF);
		`CHK(rd, 32'h00000800)
		`CHK(tx_in_ready, 1'b0)
		// Drain in order while the DMA side stays parked
		tx_out_ready <= 1;
		n = 0;
		while (n < 8)
		begin
			tick();
			if (tx_out_valid)
			begin
				`CHK(tx_out_data, n[15:0])
				n++;
			end
		end
		tx_out_ready <= 0;
		repeat (3) tick();
		axi_write(`SFC_CFG_OFF, 32'h00011001);
		`CHK(tx_out_valid, 1'b0)
		axi_read(`SFC_STAT_OFF);
		`CHK(rd, 32'h00000030)
		axi_read(`SFC_CFG_OFF);
		`CHK(rd, 32'h00001011)
		axi_write(`SFC_CFG_OFF, 32'h00001000);
		`CHK({tx_dma_request, tx_in_ready}, 2'b00)
		axi_write(`SFC_CFG_OFF, 32'h00002002);
		`CHK(rx_dma_request, 1'b0)
		push_rx(16'hA5C3);
		repeat (3) tick();
		`CHK({rx_dma_request, rx_out_data}, {1'b1, 16'hA5C3})
		axi_write(`SFC_CFG_OFF, 32'h00022002);
		`CHK({rx_dma_request, rx_out_valid}, 2'b00)
		stall <= 0;
		push_rx(16'h1234);
		while (rx_seen == 8'h00) tick();
		`CHK(rx_last, 16'h1234)
		stall <= 1;
		axi_write(`SFC_TRIG_OFF, 32'h00000002);
		axi_read(`SFC_TRIG_OFF);
		`CHK({rs, rd}, {SFC_OKAY, 32'h00000002})
		axi_write(`SFC_CFG_OFF, 32'h00004001);
		`CHK(dma_wakeup, 1'b1)
		axi_write(`SFC_CFG_OFF, 32'h00000001);
		`CHK(dma_wakeup, 1'b0)
		axi_write(`SFC_CFG_OFF, 32'h00008002);
		`CHK(dma_wakeup, 1'b0)
		push_rx(16'h0F0F);
		repeat (3) tick();
		`CHK(dma_wakeup, 1'b1)
		report_and_stop();
	end
endmodule
